//--- sim/dmcc_asserts.sv
/* port timing checker for dmcc_top: apb wait state and item bus.
   assumes one clock domain and an active low async reset. */
`timescale 1ns/1ps
`default_nettype none
module dmcc_asserts #(parameter NCH = 4, parameter CW = 2) (
    // clock, reset and apb
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // item bus and channel clocks
    input wire mst_valid,
    input wire mst_ready,
    input wire [31:0] mst_src_addr,
    input wire [31:0] mst_dst_addr,
    input wire [CW-1:0] mst_chan,
    input wire [NCH-1:0] chan_clk_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // exactly one wait state
    property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait) else $error("apb wait state wrong");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready too long");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("pready outside access");
    // refused access reads zero
    property p_err; pslverr |-> pready && prdata == 32'h00000000; endproperty
    a_err: assert property (p_err) else $error("bad refused access");
    // item request held until taken
    property p_hold;
        mst_valid && !mst_ready |=> mst_valid && $stable(mst_src_addr)
            && $stable(mst_dst_addr) && $stable(mst_chan);
    endproperty
    a_hold: assert property (p_hold) else $error("item request dropped");
    property p_gap; mst_valid && mst_ready |=> !mst_valid; endproperty
    a_gap: assert property (p_gap) else $error("no gap after item");
    property p_clk; $rose(mst_valid) |-> chan_clk_en[mst_chan]; endproperty
    a_clk: assert property (p_clk) else $error("gated channel moves");
    // read data keeps standing after the answer cycle
    property p_nerr; pready |=> $stable(prdata); endproperty
    a_nerr: assert property (p_nerr) else $error("prdata moved early");
endmodule
bind dmcc_top dmcc_asserts #(.NCH(NCH), .CW(CW)) u_dmcc_asserts (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mst_valid(mst_valid), .mst_ready(mst_ready),
    .mst_src_addr(mst_src_addr), .mst_dst_addr(mst_dst_addr),
    .mst_chan(mst_chan), .chan_clk_en(chan_clk_en));
`default_nettype wire

//--- sim/dmcc_fabric.sv
/* system bus model: takes one item per handshake.
   assumes the requester holds mst_valid until mst_ready. */
`timescale 1ns/1ps
`default_nettype none
module dmcc_fabric (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // item bus and answer delay
    input wire logic mst_valid,
    output logic mst_ready,
    input wire logic [1:0] lat
);
    logic [1:0] cnt_r;
    // one cycle ready after lat + 1 busy cycles, so slow answers get seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
            mst_ready <= 1'b0;
        end else if (mst_ready || !mst_valid) begin
            cnt_r <= 2'h0;
            mst_ready <= 1'b0;
        end else if (cnt_r == lat) begin
            mst_ready <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule
`default_nettype wire

//--- sim/testbench.sv
/* self-checking bench for dmcc_top.
   assumes dmcc_fabric and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    failures++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic mst_valid, mst_ready, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, src, dst;
    logic [3:0] periph_req, chan_clk_en;
    logic [1:0] width, chan, lat;
    logic [31:0] q_src[$], q_dst[$];
    logic [1:0] q_ch[$], q_w[$];
    int failures = 0;
    int checks_done = 0;
    dmcc_top u_dmcc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .mst_valid(mst_valid), .mst_src_addr(src),
        .mst_dst_addr(dst), .mst_width(width), .mst_chan(chan),
        .mst_ready(mst_ready), .chan_clk_en(chan_clk_en), .irq(irq));
    dmcc_fabric u_dmcc_fabric (.clk(clk), .rst_n(rst_n),
        .mst_valid(mst_valid), .mst_ready(mst_ready), .lat(lat));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // record every item taken by the bus
    always @(posedge clk) begin
        if (mst_valid && mst_ready) begin
            q_src.push_back(src);
            q_dst.push_back(dst);
            q_ch.push_back(chan);
            q_w.push_back(width);
        end
    end
    // apb master; waits for pready as long as it takes, so a dead slave
    // is caught by the watchdog and still reaches the verdict
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // program a channel, on bit last, and forget older items
    task setup(input logic [11:0] b, input logic [31:0] s, d, len, ic, ctl);
        wr(b + 12'h010, s);
        wr(b + 12'h014, d);
        wr(b + 12'h004, len);
        wr(b + 12'h008, ic);
        q_src.delete();
        q_dst.delete();
        q_ch.delete();
        q_w.delete();
        wr(b, ctl);
    endtask
    // wait for n items, then a few idle cycles to catch extra ones
    task wait_items(input int n);
        int k;
        k = 0;
        while (q_src.size() < n && k < 200) begin
            @(posedge clk);
            k++;
        end
        repeat (6) @(posedge clk);
        `CHK(q_src.size(), n)
    endtask
    task t_regs;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h00000000)
        wr(12'h000, 32'h0000FFFE);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h00003FFE)
        wr(12'h000, 32'h00000000);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK(err, 1'b1)
        $display("t_regs done");
    endtask
    task t_width;
        for (int w = 0; w < 3; w++) begin
            lat <= 2'(w + 1);
            setup(12'h000, 32'h1000, 32'h2000, 1, 16'hFFFF, 32'h61 | w << 1);
            wait_items(2);
            `CHK(q_src[0], 32'h00001000)
            `CHK(q_src[1] - q_src[0], 32'h1 << w)
            `CHK(q_dst[1] - q_dst[0], 32'h1 << w)
            `CHK(q_w[0], 2'(w))
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rd[0], 1'b0)
            apb(1'b0, 12'h00C, 32'h0);
            `CHK(rd, 32'h00000000)
        end
        $display("t_width done");
    endtask
    task t_irq;
        lat <= 2'h0;
        wr(12'h108, 32'h2);
        setup(12'h020, 32'h300, 32'h400, 2, 1, 32'h09);
        wait_items(3);
        `CHK(q_src[2], 32'h00000300)
        `CHK(q_dst[2], 32'h00000400)
        apb(1'b0, 12'h100, 32'h0);
        `CHK(rd[3:0], 4'h2)
        `CHK(irq, 1'b1)
        wr(12'h104, 32'h2);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        setup(12'h020, 32'h300, 32'h400, 2, 1, 32'h01);
        wait_items(3);
        apb(1'b0, 12'h100, 32'h0);
        `CHK(rd[3:0], 4'h0)
        $display("t_irq done");
    endtask
    task t_prio;
        setup(12'h040, 32'h0, 32'h0, 0, 16'hFFFF, 32'h311);
        setup(12'h060, 32'h0, 32'h0, 0, 16'hFFFF, 32'h511);
        setup(12'h020, 32'h0, 32'h0, 0, 16'hFFFF, 32'h511);
        wait_items(0);
        periph_req <= 4'hE;
        wait_items(3);
        periph_req <= 4'h0;
        `CHK(q_ch[0], 2'h1)
        `CHK(q_ch[1], 2'h3)
        `CHK(q_ch[2], 2'h2)
        $display("t_prio done");
    endtask
    task t_circ;
        setup(12'h000, 32'h500, 32'h600, 1, 16'hFFFF, 32'h20D1);
        for (int i = 0; i < 3; i++) begin
            periph_req <= 4'h1;
            repeat (8) @(posedge clk);
            periph_req <= 4'h0;
            repeat (4) @(posedge clk);
            `CHK(q_src.size(), i + 1)
        end
        `CHK(q_src[2], 32'h00000500)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd[0], 1'b1)
        wr(12'h000, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(chan_clk_en[0], 1'b0)
        $display("t_circ done");
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        failures++;
        give_verdict;
    end
    // reset, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        periph_req = 4'h0;
        lat = 2'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_width;
        t_irq;
        t_prio;
        t_circ;
        give_verdict;
    end
endmodule
`default_nettype wire

//--- verilog/dmcc_map.vh
/*
 * Register offsets, control field positions and reset values for the
 * DMA channel control block.
 * Assumes byte addressing on a 32-bit APB with one register per word.
 */
`ifndef DMCC_MAP_VH
`define DMCC_MAP_VH

// per-channel block: channel n starts at byte n * 32
`define DMCC_CH_SHIFT 5
`define DMCC_OFF_CTRL 5'h00
`define DMCC_OFF_LEN 5'h04
`define DMCC_OFF_ICNT 5'h08
`define DMCC_OFF_IDX 5'h0C
`define DMCC_OFF_SRC 5'h10
`define DMCC_OFF_DST 5'h14

// global interrupt registers
`define DMCC_OFF_STAT 12'h100
`define DMCC_OFF_CLR 12'h104
`define DMCC_OFF_IEN 12'h108

// control register field positions
`define DMCC_CTRL_ON 0
`define DMCC_CTRL_WID_HI 2
`define DMCC_CTRL_WID_LO 1
`define DMCC_CTRL_IRQEN 3
`define DMCC_CTRL_TRIG 4
`define DMCC_CTRL_DINC 5
`define DMCC_CTRL_SINC 6
`define DMCC_CTRL_CIRC 7
`define DMCC_CTRL_PRIO_HI 10
`define DMCC_CTRL_PRIO_LO 8
`define DMCC_CTRL_SENSE 13
`define DMCC_CTRL_WMASK 16'h3FFF

// transfer width codes
`define DMCC_WID_BYTE 2'h0
`define DMCC_WID_HALF 2'h1
`define DMCC_WID_WORD 2'h2

// reset values
`define DMCC_RST_CTRL 16'h0000
`define DMCC_RST_HALF 16'h0000
`define DMCC_RST_ADDR 32'h00000000

`endif

//--- verilog/dmcc_top.v
/*
 * Multi-channel DMA channel control: APB register file, priority
 * arbitration, address generation, trigger handling and interrupts.
 * Assumes the bus fabric moves one item per mst_valid/mst_ready
 * handshake, and peripheral requests are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dmcc_map.vh"

module dmcc_top #(
    parameter NCH = 4,
    parameter CW = 2
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // peripheral request lines, one per channel
    input wire [NCH-1:0] periph_req,
    // item transfer request to the system bus
    output reg mst_valid,
    output reg [31:0] mst_src_addr,
    output reg [31:0] mst_dst_addr,
    output reg [1:0] mst_width,
    output reg [CW-1:0] mst_chan,
    input wire mst_ready,
    // channel clock enables and interrupt
    output reg [NCH-1:0] chan_clk_en,
    output reg irq
);

    // byte offset of item idx for the given width, zero when not stepping
    function [31:0] dmcc_off;
        input [15:0] idx;
        input [1:0] wid;
        input inc_en;
        begin
            if (!inc_en) begin
                dmcc_off = 32'h00000000;
            end else if (wid == `DMCC_WID_WORD) begin
                dmcc_off = {14'h0000, idx, 2'h0};
            end else if (wid == `DMCC_WID_HALF) begin
                dmcc_off = {15'h0000, idx, 1'h0};
            end else begin
                // reserved code 11 falls back to single bytes
                dmcc_off = {16'h0000, idx};
            end
        end
    endfunction

    // channel state
    reg [15:0] ctrl_r [0:NCH-1];
    reg [15:0] len_r [0:NCH-1];
    reg [15:0] icnt_r [0:NCH-1];
    reg [15:0] idx_r [0:NCH-1];
    reg [31:0] src_r [0:NCH-1];
    reg [31:0] dst_r [0:NCH-1];
    reg [NCH-1:0] req_prev_r;
    reg [NCH-1:0] edge_pend_r;
    reg [NCH-1:0] stat_r;
    reg [NCH-1:0] ien_r;
    reg busy_r;
    reg [CW-1:0] cur_r;

    // combinational helpers
    reg [NCH-1:0] want;
    reg grant_any;
    reg [CW-1:0] grant_idx;
    reg [2:0] best_prio;
    reg [NCH-1:0] stat_set;
    reg [31:0] rdata_nxt;
    reg hit_nxt;
    integer i;

    wire item_done = busy_r & mst_valid & mst_ready;
    wire apb_end = psel & penable & pready;
    wire apb_wr = apb_end & pwrite;
    wire [CW-1:0] ap_ch = paddr[`DMCC_CH_SHIFT+CW-1:`DMCC_CH_SHIFT];
    wire [4:0] ap_off = paddr[4:0];
    wire ch_area = (paddr[11:`DMCC_CH_SHIFT+CW] == 0) &&
                   ({1'b0, ap_ch} < NCH);
    wire [15:0] cur_ctrl = ctrl_r[cur_r];
    wire done_live = item_done & cur_ctrl[`DMCC_CTRL_ON];

    // request qualification and priority pick; descending scan with >=
    // lets the lower channel number win a priority tie
    always @* begin
        want = {NCH{1'b0}};
        grant_any = 1'b0;
        grant_idx = {CW{1'b0}};
        best_prio = 3'h0;
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            want[i] = ctrl_r[i][`DMCC_CTRL_ON] & ~busy_r &
                (~ctrl_r[i][`DMCC_CTRL_TRIG] |
                 (ctrl_r[i][`DMCC_CTRL_SENSE] ? edge_pend_r[i] :
                  periph_req[i]));
            if (want[i] && (!grant_any ||
                ctrl_r[i][`DMCC_CTRL_PRIO_HI:`DMCC_CTRL_PRIO_LO] >=
                best_prio)) begin
                grant_any = 1'b1;
                grant_idx = i[CW-1:0];
                best_prio = ctrl_r[i][`DMCC_CTRL_PRIO_HI:`DMCC_CTRL_PRIO_LO];
            end
        end
    end

    // interrupt events: count matches index before it advances
    always @* begin
        stat_set = {NCH{1'b0}};
        if (done_live && cur_ctrl[`DMCC_CTRL_IRQEN] &&
            icnt_r[cur_r] == idx_r[cur_r]) begin
            stat_set[cur_r] = 1'b1;
        end
    end

    // read mux; unmapped offsets read zero and flag an error
    always @* begin
        rdata_nxt = 32'h00000000;
        hit_nxt = 1'b0;
        if (ch_area) begin
            hit_nxt = 1'b1;
            case (ap_off)
                `DMCC_OFF_CTRL: rdata_nxt = {18'h00000,
                    ctrl_r[ap_ch][13:0]};
                `DMCC_OFF_LEN: rdata_nxt = {16'h0000, len_r[ap_ch]};
                `DMCC_OFF_ICNT: rdata_nxt = {16'h0000, icnt_r[ap_ch]};
                `DMCC_OFF_IDX: rdata_nxt = {16'h0000, idx_r[ap_ch]};
                `DMCC_OFF_SRC: rdata_nxt = src_r[ap_ch];
                `DMCC_OFF_DST: rdata_nxt = dst_r[ap_ch];
                default: hit_nxt = 1'b0;
            endcase
        end else begin
            case (paddr)
                `DMCC_OFF_STAT: begin
                    hit_nxt = 1'b1;
                    rdata_nxt[NCH-1:0] = stat_r;
                end
                `DMCC_OFF_CLR: hit_nxt = 1'b1; // write-only, reads zero
                `DMCC_OFF_IEN: begin
                    hit_nxt = 1'b1;
                    rdata_nxt[NCH-1:0] = ien_r;
                end
                default: hit_nxt = 1'b0;
            endcase
        end
    end

    // apb answer: one wait state, data and error captured with pready
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rdata_nxt;
                pslverr <= ~hit_nxt;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // bus side: launch one item for the granted channel, hold until ready
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            cur_r <= {CW{1'b0}};
            mst_valid <= 1'b0;
            mst_src_addr <= `DMCC_RST_ADDR;
            mst_dst_addr <= `DMCC_RST_ADDR;
            mst_width <= `DMCC_WID_BYTE;
            mst_chan <= {CW{1'b0}};
        end else if (item_done) begin
            busy_r <= 1'b0;
            mst_valid <= 1'b0;
        end else if (grant_any) begin
            busy_r <= 1'b1;
            cur_r <= grant_idx;
            mst_chan <= grant_idx;
            mst_valid <= 1'b1;
            mst_width <=
                ctrl_r[grant_idx][`DMCC_CTRL_WID_HI:`DMCC_CTRL_WID_LO];
            mst_src_addr <= src_r[grant_idx] + dmcc_off(idx_r[grant_idx],
                ctrl_r[grant_idx][`DMCC_CTRL_WID_HI:`DMCC_CTRL_WID_LO],
                ctrl_r[grant_idx][`DMCC_CTRL_SINC]);
            mst_dst_addr <= dst_r[grant_idx] + dmcc_off(idx_r[grant_idx],
                ctrl_r[grant_idx][`DMCC_CTRL_WID_HI:`DMCC_CTRL_WID_LO],
                ctrl_r[grant_idx][`DMCC_CTRL_DINC]);
        end
    end

    // channel registers: hardware progress first, software write after,
    // so a write in the same cycle as completion takes precedence
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NCH; i = i + 1) begin
                ctrl_r[i] <= `DMCC_RST_CTRL;
                len_r[i] <= `DMCC_RST_HALF;
                icnt_r[i] <= `DMCC_RST_HALF;
                idx_r[i] <= `DMCC_RST_HALF;
                src_r[i] <= `DMCC_RST_ADDR;
                dst_r[i] <= `DMCC_RST_ADDR;
            end
        end else begin
            if (done_live) begin
                if (idx_r[cur_r] == len_r[cur_r]) begin
                    idx_r[cur_r] <= 16'h0000;
                    if (!(cur_ctrl[`DMCC_CTRL_CIRC] &&
                          cur_ctrl[`DMCC_CTRL_TRIG])) begin
                        ctrl_r[cur_r][`DMCC_CTRL_ON] <= 1'b0;
                    end // otherwise stays on
                end else begin
                    idx_r[cur_r] <= idx_r[cur_r] + 16'h0001;
                end
            end
            if (apb_wr && ch_area) begin
                case (ap_off)
                    `DMCC_OFF_CTRL: begin
                        ctrl_r[ap_ch] <= pwdata[15:0] & `DMCC_CTRL_WMASK;
                        // switching on or off always starts from item 0
                        if (pwdata[`DMCC_CTRL_ON] !=
                            ctrl_r[ap_ch][`DMCC_CTRL_ON]) begin
                            idx_r[ap_ch] <= 16'h0000;
                        end
                    end
                    `DMCC_OFF_LEN: len_r[ap_ch] <= pwdata[15:0];
                    `DMCC_OFF_ICNT: icnt_r[ap_ch] <= pwdata[15:0];
                    `DMCC_OFF_SRC: src_r[ap_ch] <= pwdata;
                    `DMCC_OFF_DST: dst_r[ap_ch] <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // edge detection for edge-sensitive requests; a new edge beats the
    // clear from the grant of the same cycle so no request is lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_r <= {NCH{1'b0}};
            edge_pend_r <= {NCH{1'b0}};
        end else begin
            req_prev_r <= periph_req;
            for (i = 0; i < NCH; i = i + 1) begin
                if (periph_req[i] && !req_prev_r[i]) begin
                    edge_pend_r[i] <= 1'b1;
                end else if ((grant_any && grant_idx == i[CW-1:0]) ||
                             !ctrl_r[i][`DMCC_CTRL_ON]) begin
                    edge_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // sticky status with write-one-to-clear; set wins over clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= {NCH{1'b0}};
            ien_r <= {NCH{1'b0}};
        end else begin
            if (apb_wr && !ch_area && paddr == `DMCC_OFF_CLR) begin
                stat_r <= (stat_r & ~pwdata[NCH-1:0]) | stat_set;
            end else begin
                stat_r <= stat_r | stat_set;
            end
            if (apb_wr && !ch_area && paddr == `DMCC_OFF_IEN) begin
                ien_r <= pwdata[NCH-1:0];
            end
        end
    end

    // registered outputs: interrupt level and per-channel clock gates
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            chan_clk_en <= {NCH{1'b0}};
        end else begin
            irq <= |(stat_r & ien_r);
            for (i = 0; i < NCH; i = i + 1) begin
                chan_clk_en[i] <= ctrl_r[i][`DMCC_CTRL_ON];
            end
        end
    end

endmodule

`default_nettype wire
